// [pkg/i2c_cfg_pkg.sv]
/*
  i2c_cfg_pkg: register offsets, configuration and status layouts,
  command bytes, timing counts and state encodings of the i2c controller.
  assumes a 250 MHz core clock and an APB host on the register side.
*/
// Notes on behaviour
// - loopback bit 6 routes own transmit lines into the receive path.
// - bit 5 set: master retries at once after lost arbitration.
// - bit 5 clear: master waits a back-off time before retrying.
// - bits 4 and 3 set: byte after call compared with alternate register.
// - bit 3 set: acknowledge write address 0x00 and take next byte.
// - general call byte 0x06 resets the interface; software reconfigures.
// - general call byte 0x04 flags it; software reprograms address.
// - any recognised general call sets the general call status flag.
// - bit 1 set enables the master channel, clear disables it.
// - bit 0 set: match transfers against four slave address registers.
// - a matching address makes the device take part as slave.
// - bit 7 set lets the master generate the serial clock.
`default_nettype none
package i2c_cfg_pkg;
  // register byte offsets
  localparam logic [7:0] CFG_OFF  = 8'h00;
  localparam logic [7:0] ALT_OFF  = 8'h04;
  localparam logic [7:0] ID0_OFF  = 8'h08;
  localparam logic [7:0] STAT_OFF = 8'h18;
  localparam logic [7:0] MASK_OFF = 8'h1c;
  localparam logic [7:0] CMD_OFF  = 8'h20;
  localparam logic [7:0] INFO_OFF = 8'h24;
  localparam int NUM_ID = 4;
  // configuration bits 7 down to 0
  typedef struct packed {
    logic scl_en;
    logic loop_en;
    logic no_backoff;
    logic hwgc_en;
    logic gc_en;
    logic rsvd;
    logic mst_en;
    logic slv_en;
  } cfg_t;
  localparam cfg_t       CFG_RST   = 8'h00;
  localparam logic [7:0] CFG_WMASK = 8'hfb;
  localparam logic [7:0] ALT_RST   = 8'h00;
  localparam logic [7:0] ID_RST    = 8'h00;
  // sticky status bits 6 down to 0
  typedef struct packed {
    logic done;
    logic arb;
    logic addr;
    logic gc_prog;
    logic gc_rst;
    logic hwgc;
    logic gc;
  } stat_t;
  localparam int STAT_W = 7;
  localparam logic [6:0] GC_ADDR      = 7'h00;
  localparam logic [7:0] GC_RESET_CMD = 8'h06;
  localparam logic [7:0] GC_PROG_CMD  = 8'h04;
  localparam logic [3:0] BITS_BYTE    = 4'h8;
  // timing
  localparam int CLK_MHZ      = 250;
  localparam int SCL_HALF_NS  = 1250;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int BACKOFF_NS   = 4000;
  localparam int BACKOFF_CYC  = (BACKOFF_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W        = 12;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ADDR = 3'b001, S_AACK = 3'b011,
    S_DATA = 3'b010, S_DACK = 3'b110
  } slv_state_t;
  typedef enum logic [2:0] {
    M_IDLE  = 3'b000, M_WAIT  = 3'b001, M_START = 3'b011,
    M_LO    = 3'b010, M_HI    = 3'b110, M_STOP1 = 3'b111,
    M_STOP2 = 3'b101, M_BACK  = 3'b100
  } mst_state_t;
endpackage
`default_nettype wire

// [logic/sync2.sv]
/*
  sync2: two flip-flop synchroniser for pin levels.
  assumes inputs idle high, as an i2c bus does.
*/
`timescale 1ns/1ns
`default_nettype none
module sync2 import i2c_cfg_pkg::*; #(
  parameter int W = 2
) (
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q;

  // first stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '1;
      q    <= '1;
    end else begin
      s1_q <= d;
      q    <= s1_q;
    end
  end
endmodule // sync2
`default_nettype wire

// [logic/i2c_master_seq.sv]
/*
  i2c_master_seq: sends start, one byte, reads the acknowledge, stop.
  assumes synchronised line levels; drives are open-drain pull requests.
*/
`timescale 1ns/1ns
`default_nettype none
module i2c_master_seq import i2c_cfg_pkg::*; #(
  parameter int HALF    = SCL_HALF_CYC,
  parameter int BACKOFF = BACKOFF_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       soft_rst,
  input  wire logic       enable,
  input  wire logic       scl_gen,
  input  wire logic       no_backoff,
  input  wire logic       go,
  input  wire logic [7:0] tx_byte,
  input  wire logic       sda_in,
  input  wire logic       scl_in,
  output logic            sda_drv,
  output logic            scl_drv,
  output logic            busy,
  output logic            backing_off,
  output logic            done,
  output logic            nack,
  output logic            arb_lost
);
  mst_state_t       st_q, st_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [3:0]       cnt_q, cnt_d;
  logic [7:0]       byte_q, byte_d;
  logic             nack_d, tick, bit_out;

  assign tick    = (tmr_q == '0);
  assign bit_out = cnt_q[3] | byte_q[~cnt_q[2:0]];

  // next state of the byte sequencer
  always_comb begin
    st_d     = st_q;
    tmr_d    = tick ? tmr_q : tmr_q - 1'b1;
    cnt_d    = cnt_q;
    byte_d   = byte_q;
    nack_d   = nack;
    done     = 1'b0;
    arb_lost = 1'b0;
    unique case (st_q)
      M_IDLE: if (go) begin
        byte_d = tx_byte;
        st_d   = M_WAIT;
      end
      M_WAIT: if (sda_in && scl_in) begin
        st_d  = M_START;
        tmr_d = TMR_W'(HALF);
      end
      M_START: if (tick && scl_gen) begin
        st_d  = M_LO;
        cnt_d = '0;
        tmr_d = TMR_W'(HALF);
      end
      M_LO: if (tick && scl_gen) begin
        st_d  = M_HI;
        tmr_d = TMR_W'(HALF);
      end
      M_HI: begin
        if (!scl_in) begin
          tmr_d = TMR_W'(HALF); // stretched by a slave
        end else if (tick) begin
          if (cnt_q == BITS_BYTE) begin
            nack_d = sda_in;
            st_d   = M_STOP1;
            tmr_d  = TMR_W'(HALF);
          end else if (bit_out && !sda_in) begin
            arb_lost = 1'b1;
            if (no_backoff) begin
              st_d = M_WAIT;
            end else begin
              st_d  = M_BACK;
              tmr_d = TMR_W'(BACKOFF);
            end
          end else begin
            cnt_d = cnt_q + 4'h1;
            st_d  = M_LO;
            tmr_d = TMR_W'(HALF);
          end
        end
      end
      M_STOP1: if (tick && scl_gen) begin
        st_d  = M_STOP2;
        tmr_d = TMR_W'(HALF);
      end
      M_STOP2: if (tick) begin
        st_d = M_IDLE;
        done = 1'b1;
      end
      M_BACK: if (tick) begin
        st_d = M_WAIT;
      end
    endcase
    if (!enable || soft_rst) begin
      st_d = M_IDLE;
    end
  end

  // sequencer registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q   <= M_IDLE;
      tmr_q  <= '0;
      cnt_q  <= '0;
      byte_q <= '0;
      nack   <= 1'b0;
    end else begin
      st_q   <= st_d;
      tmr_q  <= tmr_d;
      cnt_q  <= cnt_d;
      byte_q <= byte_d;
      nack   <= nack_d;
    end
  end

  // line drives follow the state
  assign sda_drv = (st_q == M_START) || (st_q == M_STOP1) ||
                   (st_q == M_STOP2) ||
                   (((st_q == M_LO) || (st_q == M_HI)) && !bit_out);
  assign scl_drv = scl_gen && ((st_q == M_LO) || (st_q == M_STOP1));
  assign busy        = (st_q != M_IDLE);
  assign backing_off = (st_q == M_BACK);
endmodule // i2c_master_seq
`default_nettype wire

// [logic/i2c_ctrl.sv]
/*
  i2c_ctrl: i2c controller with APB registers, slave address matching,
  general call handling, loopback and one-byte master.
  assumes an APB master on core_clk and open-drain pads outside.
*/
`timescale 1ns/1ns
`default_nettype none
module i2c_ctrl import i2c_cfg_pkg::*; #(
  parameter int HALF    = SCL_HALF_CYC,
  parameter int BACKOFF = BACKOFF_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_b,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_b,
  output logic             irq
);
  cfg_t       cfg_q, cfg_d;
  stat_t      stat_q, stat_d, stat_set;
  logic [7:0] alt_q, alt_d;
  logic [7:0] id_q [NUM_ID];
  logic [7:0] id_d [NUM_ID];
  logic [6:0] mask_q, mask_d;
  logic [7:0] rx_q, rx_d;
  logic [31:0] rd_val;
  logic       wr, rd_setup, go;

  slv_state_t s_q, s_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic       gc_q, gc_d;
  logic       scl_p_q, sda_p_q;
  logic       ev_addr, ev_gc, ev_hwgc, ev_rst, ev_prog;
  logic       gc_hit, id_hit;

  logic [1:0] pin_s;
  logic       rx_scl, rx_sda, s_sda_drv;
  logic       start_c, stop_c, scl_rise, scl_fall;
  logic       m_sda_drv, m_scl_drv, m_busy, m_backoff;
  logic       m_done, m_nack, m_arb;

  // true when the offset names a register
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == CFG_OFF) || (a == ALT_OFF) || (a == STAT_OFF) ||
             (a == MASK_OFF) || (a == CMD_OFF) || (a == INFO_OFF) ||
             ((a >= ID0_OFF) && (a < STAT_OFF) && (a[1:0] == 2'b00));
  endfunction

  // true when the 7-bit address equals any slave address register
  function automatic logic id_match(input logic [6:0] a,
                                    input logic [7:0] ids [NUM_ID]);
    id_match = 1'b0;
    for (int i = 0; i < NUM_ID; i++) begin
      if (ids[i][7:1] == a) begin
        id_match = 1'b1;
      end
    end
  endfunction

  // pin synchroniser
  sync2 #(
    .W (2)
  ) u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .d        ({scl_i, sda_i}),
    .q        (pin_s)
  );

  // receive path: own drives in loopback, pads otherwise
  assign rx_scl = cfg_q.loop_en ? !m_scl_drv : pin_s[1];
  assign rx_sda = cfg_q.loop_en ? !(m_sda_drv || s_sda_drv)
                                : pin_s[0];

  // pads released while looping back
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_b = !(m_scl_drv && !cfg_q.loop_en);
  assign sda_oe_b = !((m_sda_drv || s_sda_drv) && !cfg_q.loop_en);

  // one-byte master
  i2c_master_seq #(
    .HALF    (HALF),
    .BACKOFF (BACKOFF)
  ) u_mst (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .soft_rst    (ev_rst),
    .enable      (cfg_q.mst_en),
    .scl_gen     (cfg_q.scl_en),
    .no_backoff  (cfg_q.no_backoff),
    .go          (go),
    .tx_byte     (pwdata[7:0]),
    .sda_in      (rx_sda),
    .scl_in      (rx_scl),
    .sda_drv     (m_sda_drv),
    .scl_drv     (m_scl_drv),
    .busy        (m_busy),
    .backing_off (m_backoff),
    .done        (m_done),
    .nack        (m_nack),
    .arb_lost    (m_arb)
  );

  // bus conditions seen on the receive path
  assign start_c  = rx_scl && scl_p_q && sda_p_q && !rx_sda;
  assign stop_c   = rx_scl && scl_p_q && !sda_p_q && rx_sda;
  assign scl_rise = rx_scl && !scl_p_q;
  assign scl_fall = !rx_scl && scl_p_q;
  assign gc_hit   = cfg_q.gc_en && (sh_q[7:1] == GC_ADDR) && !sh_q[0];
  assign id_hit   = cfg_q.slv_en && id_match(sh_q[7:1], id_q);
  assign s_sda_drv = (s_q == S_AACK) || (s_q == S_DACK);

  // slave receiver next state
  always_comb begin
    s_d     = s_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    gc_d    = gc_q;
    rx_d    = rx_q;
    ev_addr = 1'b0;
    ev_gc   = 1'b0;
    ev_hwgc = 1'b0;
    ev_rst  = 1'b0;
    ev_prog = 1'b0;
    unique case (s_q)
      S_IDLE: ;
      S_ADDR, S_DATA: begin
        if (scl_rise && (cnt_q != BITS_BYTE)) begin
          sh_d  = {sh_q[6:0], rx_sda};
          cnt_d = cnt_q + 4'h1;
        end else if (scl_fall && (cnt_q == BITS_BYTE)) begin
          if (s_q == S_DATA) begin
            rx_d = sh_q;
            s_d  = S_DACK;
          end else if (gc_hit || id_hit) begin
            s_d     = S_AACK;
            ev_addr = 1'b1;
            ev_gc   = gc_hit;
            gc_d    = gc_hit;
          end else begin
            s_d = S_IDLE;
          end
        end
      end
      S_AACK: if (scl_fall) begin
        cnt_d = '0;
        s_d   = sh_q[0] ? S_IDLE : S_DATA;
      end
      S_DACK: if (scl_fall) begin
        cnt_d = '0;
        s_d   = S_DATA;
        gc_d  = 1'b0;
        if (gc_q) begin
          ev_hwgc = cfg_q.hwgc_en && (sh_q == alt_q);
          ev_rst  = (sh_q == GC_RESET_CMD);
          ev_prog = (sh_q == GC_PROG_CMD);
        end
      end
      default: s_d = S_IDLE;
    endcase
    if (start_c) begin
      s_d   = S_ADDR;
      cnt_d = '0;
      gc_d  = 1'b0;
    end else if (stop_c || (!cfg_q.slv_en && !cfg_q.gc_en)) begin
      s_d = S_IDLE;
    end
  end

  // slave registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q     <= S_IDLE;
      cnt_q   <= '0;
      sh_q    <= '0;
      gc_q    <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      s_q     <= s_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      gc_q    <= gc_d;
      scl_p_q <= rx_scl;
      sda_p_q <= rx_sda;
    end
  end

  // APB strobes; zero wait states
  assign wr       = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign go       = wr && (paddr == CMD_OFF);
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped(paddr);

  // read multiplexer, sampled in the setup cycle
  always_comb begin
    rd_val = '0;
    if (mapped(paddr)) begin
      unique case (paddr)
        CFG_OFF:  rd_val[7:0] = cfg_q & CFG_WMASK;
        ALT_OFF:  rd_val[7:0] = alt_q;
        STAT_OFF: rd_val[6:0] = stat_q;
        MASK_OFF: rd_val[6:0] = mask_q;
        INFO_OFF: rd_val[10:0] = {(s_q != S_IDLE), m_nack, m_busy, rx_q};
        CMD_OFF:  rd_val = '0;
        default:  rd_val[7:0] = id_q[paddr[3:2] - 2'b10];
      endcase
    end
  end

  // sticky events, set wins over a write-one clear
  assign stat_set = {m_done, m_arb, ev_addr, ev_prog, ev_rst,
                     ev_hwgc, ev_gc};

  // register file next values
  always_comb begin
    cfg_d  = cfg_q;
    alt_d  = alt_q;
    id_d   = id_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (wr && (paddr == STAT_OFF)) begin
      stat_d = stat_q & ~pwdata[6:0];
    end
    stat_d = stat_d | stat_set;
    if (wr) begin
      unique case (paddr)
        CFG_OFF:  cfg_d = pwdata[7:0] & CFG_WMASK;
        ALT_OFF:  alt_d = pwdata[7:0];
        MASK_OFF: mask_d = pwdata[6:0];
        default: begin
          for (int i = 0; i < NUM_ID; i++) begin
            if (paddr == ID0_OFF + 8'(4 * i)) begin
              id_d[i] = pwdata[7:0];
            end
          end
        end
      endcase
    end
    if (ev_rst) begin
      cfg_d = CFG_RST;
      alt_d = ALT_RST;
      for (int i = 0; i < NUM_ID; i++) begin
        id_d[i] = ID_RST;
      end
    end
  end

  // register file
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q  <= CFG_RST;
      alt_q  <= ALT_RST;
      mask_q <= '0;
      stat_q <= '0;
      rx_q   <= '0;
      prdata <= '0;
      irq    <= 1'b0;
      for (int i = 0; i < NUM_ID; i++) begin
        id_q[i] <= ID_RST;
      end
    end else begin
      cfg_q  <= cfg_d;
      alt_q  <= alt_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      rx_q   <= rx_d;
      prdata <= rd_setup ? rd_val : prdata;
      irq    <= |(stat_d & mask_d);
      id_q   <= id_d;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence lost_wait_s;
    m_arb && !cfg_q.no_backoff;
  endsequence
  sequence gc_cmd_s(logic [7:0] c);
    gc_q && (s_q == S_DACK) && scl_fall && (sh_q == c);
  endsequence

  loop_pins_a: assert property (
    cfg_q.loop_en |-> scl_oe_b && sda_oe_b)
    else $error("pads driven during loopback");
  loop_route_a: assert property (
    cfg_q.loop_en && m_sda_drv |-> !rx_sda)
    else $error("own sda not looped back");
  retry_now_a: assert property (
    m_arb && cfg_q.no_backoff |=> !m_backoff && m_busy)
    else $error("back-off taken while disabled");
  backoff_hold_a: assert property (
    lost_wait_s |=> m_backoff [*8])
    else $error("no back-off after lost arbitration");
  hw_call_a: assert property (
    ev_hwgc |-> cfg_q.hwgc_en && cfg_q.gc_en && (sh_q == alt_q)
    ##1 stat_q.hwgc)
    else $error("hardware general call misflagged");
  gc_ack_a: assert property (
    ev_gc |=> (s_q == S_AACK) && s_sda_drv)
    else $error("general call not acknowledged");
  gc_reset_a: assert property (
    gc_cmd_s(GC_RESET_CMD) |=> (cfg_q == CFG_RST) && stat_q.gc_rst)
    else $error("reset command did not reset");
  gc_prog_a: assert property (
    gc_cmd_s(GC_PROG_CMD) |=> stat_q.gc_prog)
    else $error("reprogram command not flagged");
  gc_flag_a: assert property (
    ev_gc |-> cfg_q.gc_en ##1 stat_q.gc)
    else $error("general call flag missing");
  mst_off_a: assert property (
    !$past(cfg_q.mst_en) |-> !m_busy && !m_sda_drv)
    else $error("master active while disabled");
  slv_match_a: assert property (
    ev_addr && !ev_gc |-> cfg_q.slv_en && id_match(sh_q[7:1], id_q))
    else $error("slave answered without match");
  slv_join_a: assert property (
    ev_addr |=> s_sda_drv ##1 (s_sda_drv || scl_fall || (s_q != S_AACK)))
    else $error("addressed slave did not join");
  scl_gen_a: assert property (
    !cfg_q.scl_en |-> !m_scl_drv)
    else $error("clock driven while disabled");
  rsvd_zero_a: assert property (
    rd_setup && (paddr == CFG_OFF) |=> !prdata[2])
    else $error("reserved bit reads one");
endmodule // i2c_ctrl
`default_nettype wire

// [tb/i2c_peer.sv]
/*
  i2c_peer: bit-banged i2c master on the far side of the pads.
  assumes open-drain lines whose pull-ups the bench resolves.
*/
`timescale 1ns/1ns
`default_nettype none
module i2c_peer (
  input  wire logic core_clk,
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic jam,
  output logic      scl_pull,
  output logic      sda_pull
);
  localparam int Q = 10;
  logic drv_q  = 1'b0;
  logic hold_q = 1'b0;
  logic scl_p  = 1'b1;
  // jam holds sda low from the next scl fall until released
  always @(posedge core_clk) begin
    scl_p  <= scl;
    hold_q <= jam && (hold_q || (scl_p && !scl));
  end
  assign sda_pull = drv_q || hold_q;
  initial scl_pull = 1'b0;
  task automatic half(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // data moves a few cycles after scl falls, sampled at end of high
  task automatic bit_io(input logic b, output logic r);
    half(3);
    drv_q <= !b;
    half(Q);
    scl_pull <= 1'b0;
    half(Q);
    r = sda;
    scl_pull <= 1'b1;
  endtask
  // start, address byte, data byte, stop; ack bit low means taken
  task automatic xfer(input logic [7:0] a, input logic [7:0] d,
                      output logic [1:0] ack);
    logic r;
    drv_q <= 1'b1;
    half(Q);
    scl_pull <= 1'b1;
    for (int i = 7; i >= 0; i--) bit_io(a[i], r);
    bit_io(1'b1, ack[1]);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, ack[0]);
    half(3);
    drv_q <= 1'b1;
    half(Q);
    scl_pull <= 1'b0;
    half(Q);
    drv_q <= 1'b0;
    half(Q);
  endtask
endmodule // i2c_peer
`default_nettype wire

// [tb/i2c_config_control_bits_test.sv]
/*
  i2c_config_control_bits_test: apb-driven checks of the controller.
  assumes i2c_ctrl, the package and the i2c_peer far-side model.
*/
`timescale 1ns/1ns
`default_nettype none
module i2c_config_control_bits_test import i2c_cfg_pkg::*;;
  localparam int HALF_T = 4;
  localparam int BOFF_T = 64;
  localparam int LIMIT  = 40000;
  logic        core_clk, rst_b, psel, penable, pwrite, jam, perr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, scl_o, sda_o, scl_oe_b, sda_oe_b, irq;
  logic        scl_pull, sda_pull, scl_p, sda_p;
  logic [1:0]  ack;
  wire logic   scl_w, sda_w;
  int          fails, tests_run, cyc, starts, falls, t0, s0, f0;
  // open-drain wires with pull-ups
  assign scl_w = (scl_oe_b ? 1'b1 : scl_o) & !scl_pull;
  assign sda_w = (sda_oe_b ? 1'b1 : sda_o) & !sda_pull;
  i2c_ctrl #(.HALF(HALF_T), .BACKOFF(BOFF_T)) u_dut (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_b(scl_oe_b), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_b(sda_oe_b), .irq(irq));
  i2c_peer u_peer (.core_clk(core_clk), .scl(scl_w), .sda(sda_w),
    .jam(jam), .scl_pull(scl_pull), .sda_pull(sda_pull));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic give_verdict;
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // cycle count, start and scl fall counts seen on the wires
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    scl_p <= scl_w;
    sda_p <= sda_w;
    if (scl_w && sda_p && !sda_w) starts <= starts + 1;
    if (scl_p && !scl_w) falls <= falls + 1;
    if (cyc == LIMIT) begin
      fails++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, r & m, exp);
  endtask
  task automatic wait_stat(input int b);
    do apb(1'b0, STAT_OFF, 32'h0); while (r[b] !== 1'b1);
  endtask
  // main sequence
  initial begin
    {cyc, starts, falls, fails, tests_run} = '0;
    {scl_p, sda_p} = 2'b11;
    {rst_b, psel, penable, pwrite, jam, paddr, pwdata} = '0;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rchk("status reset", STAT_OFF, 32'hffffffff, 32'h0);
    wr(CFG_OFF, 32'h04);
    rchk("cfg reserved", CFG_OFF, 32'hffffffff, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped err", 32'(perr), 32'h1);
    chk("unmapped data", r, 32'h0);
    // each of the four address registers is matched
    wr(CFG_OFF, 32'h01);
    for (int k = 0; k < NUM_ID; k++) begin
      wr(ID0_OFF + 8'(4*k), 32'(16 + 32*k));
      rchk("id read", ID0_OFF + 8'(4*k), 32'hff, 32'(16 + 32*k));
    end
    for (int k = 0; k < NUM_ID; k++) begin
      u_peer.xfer(8'(16 + 32*k), 8'(90 + k), ack);
      chk("slave ack", 32'(ack), 32'h0);
      rchk("rx byte", INFO_OFF, 32'hff, 32'(90 + k));
    end
    rchk("addr flag", STAT_OFF, 32'h10, 32'h10);
    u_peer.xfer(8'h12, 8'h00, ack);
    chk("stranger nack", 32'(ack[1]), 32'h1);
    // read direction: address taken, data phase left to the far side
    u_peer.xfer(8'h11, 8'h00, ack);
    chk("read address", 32'(ack), 32'h1);
    wr(CFG_OFF, 32'h00);
    u_peer.xfer(8'h10, 8'h00, ack);
    chk("slave off nack", 32'(ack[1]), 32'h1);
    // general call with the reprogram byte, interrupt in and out
    wr(STAT_OFF, 32'h7f);
    wr(MASK_OFF, 32'h01);
    wr(CFG_OFF, 32'h08);
    u_peer.xfer(8'h00, GC_PROG_CMD, ack);
    chk("gc ack", 32'(ack), 32'h0);
    rchk("gc flags", STAT_OFF, 32'h0f, 32'h09);
    chk("irq on", 32'(irq), 32'h1);
    wr(MASK_OFF, 32'h00);
    rchk("mask", MASK_OFF, 32'hff, 32'h0);
    chk("irq masked", 32'(irq), 32'h0);
    wr(ID0_OFF, 32'h10);
    wr(STAT_OFF, 32'h7f);
    wr(CFG_OFF, 32'h01);
    u_peer.xfer(8'h00, GC_PROG_CMD, ack);
    chk("gc off nack", 32'(ack[1]), 32'h1);
    rchk("gc off flag", STAT_OFF, 32'h01, 32'h0);
    // hardware general call: matching byte, then a stranger
    wr(ALT_OFF, 32'h55);
    rchk("alt read", ALT_OFF, 32'hff, 32'h55);
    wr(CFG_OFF, 32'h18);
    for (int k = 0; k < 2; k++) begin
      u_peer.xfer(8'h00, 8'(85 + 2*k), ack);
      rchk("hw call", STAT_OFF, 32'h02, k ? 32'h0 : 32'h2);
      wr(STAT_OFF, 32'h7f);
    end
    // reset command clears the configuration
    wr(CFG_OFF, 32'h19);
    u_peer.xfer(8'h00, GC_RESET_CMD, ack);
    rchk("reset flag", STAT_OFF, 32'h05, 32'h05);
    rchk("cfg cleared", CFG_OFF, 32'hff, 32'h0);
    rchk("id cleared", ID0_OFF, 32'hff, 32'h0);
    rchk("alt cleared", ALT_OFF, 32'hff, 32'h0);
    wr(ID0_OFF, 32'ha0);
    // master channel off: command ignored
    wr(CFG_OFF, 32'h81);
    wr(CMD_OFF, 32'ha0);
    repeat (40) @(posedge core_clk);
    rchk("master off", INFO_OFF, 32'h100, 32'h0);
    // loopback: own slave acks; normal mode: nobody acks
    wr(STAT_OFF, 32'h7f);
    wr(CFG_OFF, 32'hcb);
    wr(CMD_OFF, 32'ha0);
    wait_stat(6);
    rchk("loop ack", INFO_OFF, 32'h200, 32'h0);
    rchk("loop match", STAT_OFF, 32'h10, 32'h10);
    wr(STAT_OFF, 32'h7f);
    wr(CFG_OFF, 32'h82);
    f0 = falls;
    wr(CMD_OFF, 32'ha0);
    wait_stat(6);
    rchk("normal nack", INFO_OFF, 32'h200, 32'h200);
    chk("scl pulses", 32'(falls - f0 >= 9), 32'h1);
    // no clock generation: stalled after start, abort on disable
    wr(CFG_OFF, 32'h02);
    wr(CMD_OFF, 32'ha0);
    repeat (100) @(posedge core_clk);
    f0 = falls;
    repeat (100) @(posedge core_clk);
    rchk("stalled", INFO_OFF, 32'h100, 32'h100);
    chk("no scl", 32'(falls - f0), 32'h0);
    wr(CFG_OFF, 32'h00);
    rchk("aborted", INFO_OFF, 32'h100, 32'h0);
    chk("sda free", 32'(sda_w), 32'h1);
    // lost arbitration, with back-off then without
    wr(MASK_OFF, 32'h20);
    for (int nb = 0; nb < 2; nb++) begin
      wr(STAT_OFF, 32'h7f);
      wr(CFG_OFF, 32'h82 | 32'(nb << 5));
      jam <= 1'b1;
      wr(CMD_OFF, 32'hfe);
      while (irq !== 1'b1) @(posedge core_clk);
      t0 = cyc;
      s0 = starts;
      jam <= 1'b0;
      while (starts == s0) @(posedge core_clk);
      chk("quick retry", 32'(cyc - t0 < BOFF_T), 32'(nb));
      wait_stat(6);
    end
    give_verdict();
  end
endmodule // i2c_config_control_bits_test
`default_nettype wire
